// File: inc/rtcc_pkg.sv
// Shared constants and types for the clock trim, identity unlock and pin block.
// Assumes a byte-wide register access port decoded by the serial front end.
package rtcc_pkg;
    localparam logic [7:0] ADDR_CTRL  = 8'h07;
    localparam logic [7:0] ADDR_TRIM  = 8'h08;
    localparam logic [7:0] ADDR_KEY   = 8'h09;
    localparam logic [7:0] ADDR_ID_LO = 8'hf0;
    localparam logic [7:0] ADDR_ID_HI = 8'hf7;
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam int CTRL_OUT_BIT  = 7;
    localparam int CTRL_SQUARE_WAVE_ENABLE_BIT = 6;
    localparam int CTRL_ALM_HI   = 5;
    localparam int CTRL_ALM_LO   = 4;
    localparam int CTRL_RS_TOP   = 2;
    localparam int TRIM_SIGN_BIT = 7;
    localparam int ID_BYTES      = 8;
    localparam logic [14:0] SUB_LAST = 15'h7fff;
    localparam logic [5:0]  SEC_LAST = 6'h3b;
    localparam logic [8:0]  CAL_HALF = 9'h100;
    typedef enum logic [1:0] {
        KEY_LOCKED = 2'b00,
        KEY_HALF   = 2'b01,
        KEY_OPEN   = 2'b11
    } unlock_state_t;
    typedef enum logic [1:0] {
        RATE_1HZ   = 2'b00,
        RATE_DIV8  = 2'b01,
        RATE_DIV4  = 2'b10,
        RATE_UNDIV = 2'b11
    } rate_t;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       stop;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] trim;
    } cfg_t;
endpackage

// File: src/rtcc_trim_unlock_output_ctl.sv
// Trim, identity unlock, multi-function pin and supply switchover logic.
// Assumes the serial front end presents one pulse per byte and a stop pulse.
// What this block does
// R1 - Identity bytes readable locked or unlocked, writable only unlocked
// R2 - Host writes two key bytes, each alone
// R3 - Identity write commits on stop, then relocks
// R4 - Trim top bit one subtracts, zero adds
// R5 - Twice trim magnitude cycles once per minute
// R6 - Zero magnitude of either sign disables trim
// R7 - Trim applied when minute counter increments
// R8 - Square wave enable drives timing onto pin
// R9 - Codes select 32768, 8, 4, 1 cycles
// R10 - Undivided output ignores trim
// R11 - One hertz period shifts by twice magnitude
// R12 - Middle rates delayed once per minute
// R13 - Middle rates with negative trim skip cycles
// R14 - Top rate bit gives trimmed 512-cycle signal
// R15 - Pin offers level, alarm and frequency
// R16 - On backup only alarm drives the pin
// R17 - Register access refused while on backup
// R18 - Counters keep running on backup
// R19 - Pin follows output bit when wave and alarm both off
// R20 - Alarm drives polarity level, idle inverse
// R21 - Backup flag set on switchover, software clears
// R22 - Stray key writes cancel unlock progress
`timescale 1ns/10ps
`default_nettype none
module rtcc_trim_unlock_output_ctl (
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    input  wire logic              osc_clk_in,
    input  wire rtcc_pkg::reg_req_t reg_req_in,
    output logic [7:0]             reg_rdata_out,
    output logic                   reg_ack_out,
    input  wire logic              vcc_above_trip_in,
    input  wire logic              vcc_above_bat_in,
    input  wire logic              alarm_trig_in,
    input  wire logic              alarm_polarity_in,
    input  wire logic              backup_flag_clr_in,
    output logic                   backup_flag_out,
    output logic                   id_unlocked_out,
    output logic                   multi_function_pin_out,
    output logic                   multi_function_pin_oe_out
);
    function automatic logic is_id(input logic [7:0] a);
        return (a >= rtcc_pkg::ADDR_ID_LO) && (a <= rtcc_pkg::ADDR_ID_HI);
    endfunction
    function automatic logic is_mapped(input logic [7:0] a);
        return is_id(a) || (a == rtcc_pkg::ADDR_CTRL) || (a == rtcc_pkg::ADDR_TRIM)
            || (a == rtcc_pkg::ADDR_KEY);
    endfunction
    // Synchronisers into the bus clock
    logic trip_s1, trip_s2, bat_s1, bat_s2;
    logic wave_s1, wave_s2, osc_s1, osc_s2, ack_s1, ack_s2;
    logic wave_r, ack_tgl_o, rst_hold_r;
    logic [3:0] rst_cnt_r, rst_cnt_nxt;
    always_ff @(posedge clk_in) begin
        trip_s1 <= vcc_above_trip_in;
        trip_s2 <= trip_s1;
        bat_s1  <= vcc_above_bat_in;
        bat_s2  <= bat_s1;
        wave_s1 <= wave_r;
        wave_s2 <= wave_s1;
        osc_s1  <= osc_clk_in;
        osc_s2  <= osc_s1;
        ack_s1  <= ack_tgl_o;
        ack_s2  <= ack_s1;
        rst_hold_r <= srst_in || (rst_cnt_r != 4'h0);
    end
    logic on_backup, acc_ok;
    // R17 - access gate
    assign on_backup = !trip_s2 && !bat_s2;
    assign acc_ok    = !on_backup;
    // Register file and unlock sequencer
    logic [7:0]              ctrl_r, ctrl_nxt, trim_r, trim_nxt, rdata_r, rdata_nxt;
    logic [7:0]              key_data_r, key_data_nxt;
    logic                    key_hit_r, key_hit_nxt;
    logic [1:0]              wr_cnt_r, wr_cnt_nxt;
    rtcc_pkg::unlock_state_t key_st_r, key_st_nxt;
    logic [7:0]              id_mem_r [rtcc_pkg::ID_BYTES];
    logic [7:0]              id_mem_nxt [rtcc_pkg::ID_BYTES];
    logic [7:0]              stage_r [rtcc_pkg::ID_BYTES];
    logic [7:0]              stage_nxt [rtcc_pkg::ID_BYTES];
    logic [rtcc_pkg::ID_BYTES-1:0] mask_r, mask_nxt;
    logic                    wr_ok, rd_ok;
    logic [2:0]              id_idx;
    assign wr_ok  = reg_req_in.wr && acc_ok;
    assign rd_ok  = reg_req_in.rd && acc_ok;
    assign id_idx = reg_req_in.addr[2:0];
    always_comb begin
        ctrl_nxt     = ctrl_r;
        trim_nxt     = trim_r;
        rdata_nxt    = rdata_r;
        key_data_nxt = key_data_r;
        key_hit_nxt  = key_hit_r;
        wr_cnt_nxt   = wr_cnt_r;
        key_st_nxt   = key_st_r;
        id_mem_nxt   = id_mem_r;
        stage_nxt    = stage_r;
        mask_nxt     = mask_r;
        if (wr_ok) begin
            if (wr_cnt_r != 2'h3) begin
                wr_cnt_nxt = wr_cnt_r + 2'h1;
            end
            case (reg_req_in.addr)
                rtcc_pkg::ADDR_CTRL: ctrl_nxt = reg_req_in.wdata;
                rtcc_pkg::ADDR_TRIM: trim_nxt = reg_req_in.wdata;
                rtcc_pkg::ADDR_KEY: begin
                    key_hit_nxt  = 1'b1;
                    key_data_nxt = reg_req_in.wdata;
                end
                default: begin
                    // R1 - locked writes dropped
                    if (is_id(reg_req_in.addr) && key_st_r == rtcc_pkg::KEY_OPEN) begin
                        stage_nxt[id_idx] = reg_req_in.wdata;
                        mask_nxt[id_idx]  = 1'b1;
                    end
                end
            endcase
        end
        if (rd_ok) begin
            // R1 - reads allowed locked or unlocked
            if (is_id(reg_req_in.addr)) begin
                rdata_nxt = id_mem_r[id_idx];
            end else if (reg_req_in.addr == rtcc_pkg::ADDR_CTRL) begin
                rdata_nxt = ctrl_r;
            end else if (reg_req_in.addr == rtcc_pkg::ADDR_TRIM) begin
                rdata_nxt = trim_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
        if (reg_req_in.stop) begin
            wr_cnt_nxt  = 2'h0;
            key_hit_nxt = 1'b0;
            mask_nxt    = '0;
            if (mask_r != '0) begin
                // R3 - commit then relock
                for (int i = 0; i < rtcc_pkg::ID_BYTES; i++) begin
                    if (mask_r[i]) begin
                        id_mem_nxt[i] = stage_r[i];
                    end
                end
                key_st_nxt = rtcc_pkg::KEY_LOCKED;
            end else if (key_hit_r) begin
                // R22 - anything off sequence relocks
                key_st_nxt = rtcc_pkg::KEY_LOCKED;
                if (wr_cnt_r == 2'h1) begin
                    // R2 - lone key byte advances
                    if (key_st_r == rtcc_pkg::KEY_LOCKED && key_data_r == rtcc_pkg::KEY_FIRST) begin
                        key_st_nxt = rtcc_pkg::KEY_HALF;
                    end else if (key_st_r == rtcc_pkg::KEY_HALF
                                 && key_data_r == rtcc_pkg::KEY_SECOND) begin
                        key_st_nxt = rtcc_pkg::KEY_OPEN;
                    end
                end
            end
        end
    end
    // Identity bytes model nonvolatile storage, so reset leaves them alone
    always_ff @(posedge clk_in) begin
        id_mem_r <= id_mem_nxt;
        stage_r  <= stage_nxt;
        if (srst_in) begin
            ctrl_r     <= rtcc_pkg::CTRL_RESET;
            trim_r     <= rtcc_pkg::TRIM_RESET;
            rdata_r    <= 8'h00;
            key_data_r <= 8'h00;
            key_hit_r  <= 1'b0;
            wr_cnt_r   <= 2'h0;
            key_st_r   <= rtcc_pkg::KEY_LOCKED;
            mask_r     <= '0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            trim_r     <= trim_nxt;
            rdata_r    <= rdata_nxt;
            key_data_r <= key_data_nxt;
            key_hit_r  <= key_hit_nxt;
            wr_cnt_r   <= wr_cnt_nxt;
            key_st_r   <= key_st_nxt;
            mask_r     <= mask_nxt;
        end
    end
    assign reg_rdata_out   = rdata_r;
    assign reg_ack_out     = (reg_req_in.wr || reg_req_in.rd) && acc_ok
                             && is_mapped(reg_req_in.addr);
    assign id_unlocked_out = (key_st_r == rtcc_pkg::KEY_OPEN);
    // Backup flag, pin driver and config hand-off
    logic          bk_flag_r, bk_flag_nxt, bk_prev_r;
    logic          pin_oe_r, pin_oe_nxt, req_tgl_r, req_tgl_nxt;
    rtcc_pkg::cfg_t hold_r, hold_nxt;
    logic          pin_lvl;
    always_comb begin
        // Stretch reset so the slower oscillator domain always sees it
        rst_cnt_nxt = (rst_cnt_r != 4'h0) ? rst_cnt_r - 4'h1 : 4'h0;
        // R21 - set beats clear
        bk_flag_nxt = (on_backup && !bk_prev_r) || (bk_flag_r && !backup_flag_clr_in);
        hold_nxt    = hold_r;
        req_tgl_nxt = req_tgl_r;
        if ((req_tgl_r == ack_s2) && (hold_r != {ctrl_r, trim_r})) begin
            hold_nxt    = {ctrl_r, trim_r};
            req_tgl_nxt = !req_tgl_r;
        end
        pin_lvl = 1'b1;
        // R15 - three pin functions
        if (acc_ok && ctrl_r[rtcc_pkg::CTRL_SQUARE_WAVE_ENABLE_BIT]) begin
            // R8 - wave onto pin
            // R10 - raw oscillator untrimmed
            if (!ctrl_r[rtcc_pkg::CTRL_RS_TOP] && ctrl_r[1:0] == rtcc_pkg::RATE_UNDIV) begin
                pin_lvl = osc_s2;
            end else begin
                pin_lvl = wave_s2;
            end
        end else if (ctrl_r[rtcc_pkg::CTRL_ALM_HI:rtcc_pkg::CTRL_ALM_LO] != 2'h0) begin
            // R20 - alarm polarity level
            pin_lvl = alarm_trig_in ? alarm_polarity_in : !alarm_polarity_in;
        end else if (acc_ok) begin
            // R19 - static output bit
            pin_lvl = ctrl_r[rtcc_pkg::CTRL_OUT_BIT];
        end
        // R16 - backup keeps only alarm
        pin_oe_nxt = !pin_lvl;
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rst_cnt_r <= '1;
            bk_flag_r <= 1'b0;
            bk_prev_r <= 1'b0;
            pin_oe_r  <= 1'b0;
            req_tgl_r <= 1'b0;
            hold_r    <= {rtcc_pkg::CTRL_RESET, rtcc_pkg::TRIM_RESET};
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
            bk_flag_r <= bk_flag_nxt;
            bk_prev_r <= on_backup;
            pin_oe_r  <= pin_oe_nxt;
            req_tgl_r <= req_tgl_nxt;
            hold_r    <= hold_nxt;
        end
    end
    assign backup_flag_out           = bk_flag_r;
    assign multi_function_pin_out    = 1'b0;
    assign multi_function_pin_oe_out = pin_oe_r;
    // Oscillator domain: reset and config crossing
    logic           orst_s1, orst_s2, req_s1, req_s2;
    rtcc_pkg::cfg_t cfg_o;
    always_ff @(posedge osc_clk_in) begin
        orst_s1   <= rst_hold_r;
        orst_s2   <= orst_s1;
        req_s1    <= req_tgl_r;
        req_s2    <= req_s1;
        ack_tgl_o <= orst_s2 ? 1'b0 : req_s2;
        if (orst_s2) begin
            cfg_o <= {rtcc_pkg::CTRL_RESET, rtcc_pkg::TRIM_RESET};
        end else if (req_s2 != ack_tgl_o) begin
            // Held stable by the bus side until this toggle returns
            cfg_o <= hold_r;
        end
    end
    // Timing chain; runs on backup as well
    logic [14:0] sub_r, sub_nxt;
    logic [5:0]  sec_r, sec_nxt;
    logic [7:0]  stall_r, stall_nxt, twice;
    logic [8:0]  cal_r, cal_nxt, half;
    logic        cal_lvl_r, cal_lvl_nxt, wave_nxt, trim_on, trim_neg;
    // R4 - sign bit
    assign trim_neg = cfg_o.trim[rtcc_pkg::TRIM_SIGN_BIT];
    // R6 - zero magnitude off
    assign trim_on  = (cfg_o.trim[6:0] != 7'h00);
    // R5 - two cycles per step
    assign twice    = {cfg_o.trim[6:0], 1'b0};
    always_comb begin
        sub_nxt   = sub_r;
        sec_nxt   = sec_r;
        stall_nxt = stall_r;
        // R18 - no supply gating here
        if (stall_r != 8'h00) begin
            // R12 - added cycles freeze waves
            stall_nxt = stall_r - 8'h01;
        end else if (sub_r == rtcc_pkg::SUB_LAST) begin
            sub_nxt = 15'h0000;
            sec_nxt = sec_r + 6'h01;
            if (sec_r == rtcc_pkg::SEC_LAST) begin
                sec_nxt = 6'h00;
                // R7 - trim at minute step
                if (trim_on && trim_neg) begin
                    // R13 - subtracted cycles skipped
                    sub_nxt = {7'h00, twice};
                end else if (trim_on) begin
                    stall_nxt = twice;
                end
            end
        end else begin
            sub_nxt = sub_r + 15'h0001;
        end
        // R14 - every half period trimmed
        half = rtcc_pkg::CAL_HALF;
        if (trim_on) begin
            half = trim_neg ? rtcc_pkg::CAL_HALF - {1'b0, twice}
                            : rtcc_pkg::CAL_HALF + {1'b0, twice};
        end
        cal_lvl_nxt = cal_lvl_r;
        cal_nxt     = cal_r + 9'h001;
        if (cal_r >= half - 9'h001) begin
            cal_nxt     = 9'h000;
            cal_lvl_nxt = !cal_lvl_r;
        end
        // R9 - rate decode
        case (rtcc_pkg::rate_t'(cfg_o.ctrl[1:0]))
            // R11 - one second follows trimmed chain
            rtcc_pkg::RATE_1HZ:  wave_nxt = !sub_r[14];
            rtcc_pkg::RATE_DIV8: wave_nxt = sub_r[2];
            rtcc_pkg::RATE_DIV4: wave_nxt = sub_r[1];
            default:             wave_nxt = sub_r[0];
        endcase
        if (cfg_o.ctrl[rtcc_pkg::CTRL_RS_TOP]) begin
            wave_nxt = cal_lvl_r;
        end
    end
    always_ff @(posedge osc_clk_in) begin
        if (orst_s2) begin
            sub_r     <= 15'h0000;
            sec_r     <= 6'h00;
            stall_r   <= 8'h00;
            cal_r     <= 9'h000;
            cal_lvl_r <= 1'b0;
            wave_r    <= 1'b0;
        end else begin
            sub_r     <= sub_nxt;
            sec_r     <= sec_nxt;
            stall_r   <= stall_nxt;
            cal_r     <= cal_nxt;
            cal_lvl_r <= cal_lvl_nxt;
            wave_r    <= wave_nxt;
        end
    end
endmodule
`default_nettype wire

// File: bench/rtcc_chk_asserts.sv
// Concurrent checks on the top ports of the trim, unlock and pin block.
// Assumes one bus clock domain for everything watched here.
`timescale 1ns/10ps
`default_nettype none
module rtcc_chk (
    input wire logic               clk_in,
    input wire logic               srst_in,
    input wire rtcc_pkg::reg_req_t reg_req_in,
    input wire logic [7:0]         reg_rdata_out,
    input wire logic               reg_ack_out,
    input wire logic               vcc_above_trip_in,
    input wire logic               vcc_above_bat_in,
    input wire logic               backup_flag_clr_in,
    input wire logic               backup_flag_out,
    input wire logic               id_unlocked_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence key_wr(logic [7:0] v);
        reg_ack_out && reg_req_in.wr && reg_req_in.addr == rtcc_pkg::ADDR_KEY
            && reg_req_in.wdata == v;
    endsequence
    sequence stop_c;
        reg_req_in.stop;
    endsequence
    sequence id_wr;
        reg_ack_out && reg_req_in.wr && id_unlocked_out
            && reg_req_in.addr inside {[rtcc_pkg::ADDR_ID_LO:rtcc_pkg::ADDR_ID_HI]};
    endsequence
    sequence bad_key;
        reg_ack_out && reg_req_in.wr && reg_req_in.addr == rtcc_pkg::ADDR_KEY
            && reg_req_in.wdata != rtcc_pkg::KEY_FIRST
            && reg_req_in.wdata != rtcc_pkg::KEY_SECOND;
    endsequence
    a_unlock_keys: assert property (
        key_wr(rtcc_pkg::KEY_FIRST) ##[1:3] stop_c ##[2:4] key_wr(rtcc_pkg::KEY_SECOND)
        ##[1:3] stop_c |=> id_unlocked_out) else $error("unlock sequence ignored");
    a_relock_at_stop: assert property (
        id_wr ##[1:3] stop_c |=> !id_unlocked_out) else $error("area not relocked");
    a_bad_key_locks: assert property (
        bad_key ##[1:3] stop_c |=> !id_unlocked_out) else $error("stray key left open");
    a_refuse_on_backup: assert property (
        (!vcc_above_trip_in && !vcc_above_bat_in)[*4] |-> !reg_ack_out)
        else $error("access taken on backup");
    a_access_on_main: assert property (
        vcc_above_trip_in[*4] ##0 ((reg_req_in.wr || reg_req_in.rd)
        && reg_req_in.addr == rtcc_pkg::ADDR_CTRL) |-> reg_ack_out)
        else $error("access refused on main");
    a_unmapped_no_ack: assert property (
        (reg_req_in.wr || reg_req_in.rd) && reg_req_in.addr inside {[8'h0a:8'hef]}
        |-> !reg_ack_out) else $error("unmapped address acked");
    a_key_reads_zero: assert property (
        reg_req_in.rd && reg_ack_out && reg_req_in.addr == rtcc_pkg::ADDR_KEY
        |=> reg_rdata_out == 8'h00) else $error("key location readable");
    a_flag_sets: assert property (
        (vcc_above_trip_in || vcc_above_bat_in) ##1
        (!vcc_above_trip_in && !vcc_above_bat_in && !backup_flag_clr_in)[*5]
        |-> backup_flag_out) else $error("backup flag not set");
    a_flag_sticky: assert property (
        backup_flag_out && !backup_flag_clr_in |=> backup_flag_out)
        else $error("backup flag dropped");
endmodule
bind rtcc_trim_unlock_output_ctl rtcc_chk u_chk (.clk_in(clk_in), .srst_in(srst_in),
    .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
    .vcc_above_trip_in(vcc_above_trip_in), .vcc_above_bat_in(vcc_above_bat_in),
    .backup_flag_clr_in(backup_flag_clr_in), .backup_flag_out(backup_flag_out),
    .id_unlocked_out(id_unlocked_out));
`default_nettype wire

// File: bench/host_model.sv
// Host side of the byte register port, one request per call.
// Assumes requests are taken on the rising bus clock edge.
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic               clk_in,
    input  wire logic               ack_in,
    input  wire logic [7:0]         rdata_in,
    output var rtcc_pkg::reg_req_t  req_out
);
    logic       ack_seen;
    logic [7:0] rd_seen;
    initial req_out = '0;
    // Released lines show inverted values so stale data never looks valid
    task automatic cyc(input logic w, r, s, input logic [7:0] a, d);
        @(posedge clk_in);
        req_out <= '{wr: w, rd: r, stop: s, addr: a, wdata: d};
        @(posedge clk_in);
        ack_seen = ack_in;
        req_out <= '{wr: 1'b0, rd: 1'b0, stop: 1'b0, addr: ~a, wdata: ~d};
        @(posedge clk_in);
        rd_seen = rdata_in;
    endtask
    task automatic wr(input logic [7:0] a, d);
        cyc(1'b1, 1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        cyc(1'b0, 1'b1, 1'b0, a, 8'h00);
    endtask
    task automatic stop();
        cyc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
    endtask
    task automatic txn(input logic [7:0] a, d);
        wr(a, d);
        stop();
    endtask
endmodule
`default_nettype wire

// File: bench/tb_rtcc_trim_unlock_output_ctl.sv
// Self-checking bench for the trim, unlock and pin block.
// Host model drives the register port; oscillator period 125 ns.
`timescale 1ns/10ps
`default_nettype none
module tb_rtcc_trim_unlock_output_ctl;
    logic               clk_in = 1'b0;
    logic               osc_clk_in = 1'b0;
    logic               srst_in = 1'b1;
    logic               trip = 1'b1;
    logic               bat = 1'b1;
    logic               trig = 1'b0;
    logic               pol = 1'b0;
    logic               clr = 1'b0;
    rtcc_pkg::reg_req_t req;
    logic [7:0]         rdata;
    logic               ack;
    logic               flag;
    logic               unl;
    logic               oe;
    logic               pin_d;
    int                 n_errors = 0;
    int                 n_compared = 0;
    int                 cycles = 0;
    always #12.5 clk_in = ~clk_in;
    initial begin
        #3.3;
        forever #62.5 osc_clk_in = ~osc_clk_in;
    end
    host_model h (.clk_in(clk_in), .ack_in(ack), .rdata_in(rdata), .req_out(req));
    rtcc_trim_unlock_output_ctl uut (.clk_in(clk_in), .srst_in(srst_in),
        .osc_clk_in(osc_clk_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .reg_ack_out(ack), .vcc_above_trip_in(trip), .vcc_above_bat_in(bat),
        .alarm_trig_in(trig), .alarm_polarity_in(pol), .backup_flag_clr_in(clr),
        .backup_flag_out(flag), .id_unlocked_out(unl), .multi_function_pin_out(pin_d),
        .multi_function_pin_oe_out(oe));
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 90000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic t_reset();
        h.rd(rtcc_pkg::ADDR_CTRL);
        check("ctrl", h.rd_seen, rtcc_pkg::CTRL_RESET);
        h.rd(rtcc_pkg::ADDR_TRIM);
        check("trim", h.rd_seen, rtcc_pkg::TRIM_RESET);
        check("flag", flag, 1'b0);
        check("static low", oe, 1'b1);
        check("pin drive level", pin_d, 1'b0);
        h.rd(8'h20);
        check("unmapped ack", h.ack_seen, 1'b0);
        h.rd(rtcc_pkg::ADDR_KEY);
        check("key read", h.rd_seen, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_unlock();
        h.txn(rtcc_pkg::ADDR_KEY, 8'h55);
        h.txn(rtcc_pkg::ADDR_KEY, 8'haa);
        check("unlocked", unl, 1'b1);
        h.wr(8'hf3, 8'h11);
        h.wr(8'hf4, 8'h22);
        h.stop();
        check("relocked", unl, 1'b0);
        h.txn(8'hf3, 8'h5a);
        h.rd(8'hf3);
        check("id3", h.rd_seen, 8'h11);
        h.rd(8'hf4);
        check("id4", h.rd_seen, 8'h22);
        h.txn(rtcc_pkg::ADDR_KEY, 8'haa);
        h.txn(rtcc_pkg::ADDR_KEY, 8'h55);
        h.txn(rtcc_pkg::ADDR_KEY, 8'h33);
        h.txn(rtcc_pkg::ADDR_KEY, 8'haa);
        check("bad key", unl, 1'b0);
        h.txn(rtcc_pkg::ADDR_KEY, 8'h55);
        h.txn(rtcc_pkg::ADDR_CTRL, 8'h00);
        h.txn(rtcc_pkg::ADDR_KEY, 8'haa);
        check("unlock across", unl, 1'b1);
        h.txn(8'hf0, 8'h77);
        h.rd(8'hf0);
        check("id0", h.rd_seen, 8'h77);
        check("relock byte", unl, 1'b0);
        $display("unlock test done");
    endtask
    task automatic t_pin();
        h.txn(rtcc_pkg::ADDR_CTRL, 8'h80);
        repeat (10) @(posedge clk_in);
        check("static high", oe, 1'b0);
        h.txn(rtcc_pkg::ADDR_CTRL, 8'h10);
        pol <= 1'b1;
        trig <= 1'b1;
        repeat (10) @(posedge clk_in);
        check("alarm on", oe, 1'b0);
        trig <= 1'b0;
        repeat (10) @(posedge clk_in);
        check("alarm idle", oe, 1'b1);
        $display("pin test done");
    endtask
    // Pin rising edge is the enable falling; sampled away from the launch edge
    task automatic rise_wait(output time t);
        logic prev;
        prev = oe;
        @(negedge clk_in);
        while (!(prev && !oe)) begin
            prev = oe;
            @(negedge clk_in);
        end
        t = $time;
    endtask
    task automatic t_wave();
        logic [31:0] tab [8] = '{32'h41000008, 32'h41050008, 32'h42000004, 32'h43850001,
            32'h44000200, 32'h44050214, 32'h478501ec, 32'h44800200};
        time t0;
        time t1;
        foreach (tab[i]) begin
            h.txn(rtcc_pkg::ADDR_CTRL, tab[i][31:24]);
            h.txn(rtcc_pkg::ADDR_TRIM, tab[i][23:16]);
            repeat (20) @(posedge clk_in);
            rise_wait(t0);
            rise_wait(t0);
            rise_wait(t1);
            check("period", 32'((t1 - t0 + 62) / 125), tab[i][15:0]);
        end
        $display("wave test done");
    endtask
    task automatic t_backup();
        h.txn(rtcc_pkg::ADDR_CTRL, 8'h50);
        pol <= 1'b0;
        trig <= 1'b1;
        trip <= 1'b0;
        bat <= 1'b0;
        repeat (10) @(posedge clk_in);
        check("flag set", flag, 1'b1);
        h.rd(rtcc_pkg::ADDR_CTRL);
        check("refused", h.ack_seen, 1'b0);
        repeat (8) begin
            repeat (5) @(negedge clk_in);
            check("alarm only", oe, 1'b1);
        end
        @(posedge clk_in);
        trig <= 1'b0;
        clr <= 1'b1;
        @(posedge clk_in);
        clr <= 1'b0;
        repeat (5) @(posedge clk_in);
        check("alarm idle bat", oe, 1'b0);
        check("flag clear", flag, 1'b0);
        trip <= 1'b1;
        repeat (5) @(posedge clk_in);
        h.rd(rtcc_pkg::ADDR_CTRL);
        check("access trip", h.rd_seen, 8'h50);
        bat <= 1'b1;
        $display("backup test done");
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        t_reset();
        t_unlock();
        t_pin();
        t_wave();
        t_backup();
        print_verdict();
    end
endmodule
`default_nettype wire
